// ===== hdl/bacl_pkg.sv
package bacl_pkg;
  // register byte addresses on the register port
  localparam logic [7:0] AUDIO_CONFIGURATION_ADDR   = 8'h55;
  localparam logic [7:0] LINK_AND_INPUT_STATUS_ADDR = 8'h5A;
  localparam logic [7:0] BRIDGE_CONFIGURATION_ADDR  = 8'h54;
  // audio configuration field positions
  localparam int TDM_PARALLEL_BIT      = 7;
  localparam int HDMI_I2S_OUT_BIT      = 6;
  localparam int RESET_ON_TYPE_BIT     = 3;
  localparam int RESET_ON_AUD_IF_BIT   = 2;
  localparam int RESET_ON_VID_IF_BIT   = 1;
  localparam int RESET_ON_CLK_REGEN_BIT = 0;
  localparam logic [7:0] AUDIO_CONFIGURATION_RESET = 8'h0C;
  localparam logic [7:0] AUDIO_CONFIGURATION_MASK  = 8'hCF;
  // bridge configuration: audio source select bit
  localparam int AUDIO_SOURCE_BIT = 1;
  localparam logic [7:0] BRIDGE_CONFIGURATION_RESET = 8'h00;
  // status field positions
  localparam int LINK_READY_BIT  = 7;
  localparam int TX_STATUS_BIT   = 6;
  localparam int PORT_MODE_LSB   = 4;
  localparam int TMDS_DATA_VALID_BIT  = 3;
  localparam int PLL_LOCK_BIT    = 2;
  localparam int NO_CLOCK_BIT    = 1;
  localparam int INPUT_FREQUENCY_STABLE_BIT = 0;
  // port mode encodings
  typedef enum logic [1:0] {
    BACL_DUAL       = 2'h0,
    BACL_SINGLE_P0  = 2'h1,
    BACL_SINGLE_P1  = 2'h2,
    BACL_REPLICATE  = 2'h3
  } bacl_port_mode_e;
  localparam logic [1:0] PORT_MODE_RESET = 2'h0;
  localparam int SYNC_STAGES = 3;
endpackage : bacl_pkg

// ===== hdl/bacl_sync.sv
// three-stage pin synchroniser, change taken when stages two and three agree
module bacl_sync
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic pinIn,
  output logic      level
);
  logic stageA; // metastability catcher, read only by stageB
  logic stageB; // second stage
  logic stageC; // third stage

  // shift chain
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stageA <= 1'b0;
      stageB <= 1'b0;
      stageC <= 1'b0;
    end
    else
    begin
      stageA <= pinIn;
      stageB <= stageA;
      stageC <= stageB;
    end
  end

  // accept a new level once the last two stages agree
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      level <= 1'b0;
    else if (stageB == stageC)
      level <= stageC;
  end
endmodule : bacl_sync

// ===== hdl/bacl_change_det.sv
// flags a change in a watched word, only while the watch is armed
module bacl_change_det
#(
  parameter int WIDTH = 8
)
(
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             sampleValid,
  input  wire logic [WIDTH-1:0] watched,
  input  wire logic             armed,
  output logic                  changed
);
  logic [WIDTH-1:0] lastValue; // last sampled word
  logic             seen;      // a first value has been held

  // remember last value and compare with the new one
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lastValue <= '0;
      seen      <= 1'b0;
      changed   <= 1'b0;
    end
    else
    begin
      changed <= 1'b0;
      if (sampleValid)
      begin
        lastValue <= watched;
        seen      <= 1'b1;
        // first sample is a baseline, not a change
        changed   <= armed && seen && (watched != lastValue);
      end
    end
  end
endmodule : bacl_change_det

// ===== hdl/bacl_regs.sv
// Notes on behaviour
// - bit 7 set enables tdm-to-parallel converter
// - converter clock sends audio while enabled
// - bit 6 drives hdmi i2s onto pins
// - output enable ignored unless source is hdmi
// - bit 3 resets fifo on type change
// - bit 2 resets fifo on audio checksum change
// - bit 1 resets fifo on video checksum change
// - bit 0 resets fifo on N/CTS change
// - status bit 7 shows downstream link ready
// - status bit 6 shows transmitter active, locked
// - transmit status needs valid input, correct mode
// - bits 5:4 give port mode when transmitting
// - status bit 3 shows tmds data valid
// - status bit 2 shows hdmi pll locked
// - status bit 0 shows frequency stable
// - source select 0 hdmi, 1 local i2s
module bacl_regs
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // register port
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  output logic            regRdValid,
  // link and input state
  input  wire logic       downstream_link_ready,
  input  wire logic       remoteLocked,
  input  wire logic       transmitterActive,
  input  wire logic       modeSettled,
  input  wire logic [1:0] portModeIn,
  input  wire logic       tmds_data_valid,
  input  wire logic       hdmiPllLock,
  input  wire logic       tmdsClockPresent,
  input  wire logic       input_frequency_stable,
  // audio event sources, same clock domain
  input  wire logic       audioInfoValid,
  input  wire logic [3:0] audioType,
  input  wire logic [7:0] audioIfChecksum,
  input  wire logic [7:0] videoIfChecksum,
  input  wire logic [39:0] clockRegenNCts,
  // audio clocks and data
  input  wire logic       hdmiI2sClk,
  input  wire logic       hdmiI2sData,
  input  wire logic       hdmiI2sWs,
  input  wire logic       tdmConvClk,
  input  wire logic       hdmiAudioClk,
  // outputs
  output logic            tdmParallelEnable,
  output logic            audioTxClk,
  output logic            audioFromLocal,
  output logic            i2sClkOut,
  output logic            i2sDataOut,
  output logic            i2sWsOut,
  output logic            i2sPinOe,
  output logic            audioFifoReset
);
  logic [7:0] audio_configuration;  // rw audio settings
  logic [7:0] bridge_configuration; // holds audio source select
  logic [7:0] link_and_input_status; // assembled read-only status
  logic       linkReadyS;     // synchronised pin levels
  logic       remoteLockedS;
  logic       txActiveS;
  logic       modeSettledS;
  logic       tmdsValidS;
  logic       pllLockS;
  logic       clkPresentS;
  logic       freqStableS;
  logic [1:0] portModeS;
  logic       typeChanged;    // per-event change pulses
  logic       audIfChanged;
  logic       vidIfChanged;
  logic       regenChanged;
  logic       txStatus;       // combined transmit status
  logic       hdmiOutAllowed; // pin output gated by source

  // bring each status pin into sys_clk
  bacl_sync uLinkReady
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pinIn   (downstream_link_ready),
    .level   (linkReadyS)
  );
  bacl_sync uRemLock
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pinIn   (remoteLocked),
    .level   (remoteLockedS)
  );
  bacl_sync uTxAct
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pinIn   (transmitterActive),
    .level   (txActiveS)
  );
  bacl_sync uMode
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pinIn   (modeSettled),
    .level   (modeSettledS)
  );
  bacl_sync uTmds
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pinIn   (tmds_data_valid),
    .level   (tmdsValidS)
  );
  bacl_sync uPll
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pinIn   (hdmiPllLock),
    .level   (pllLockS)
  );
  bacl_sync uClk
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pinIn   (tmdsClockPresent),
    .level   (clkPresentS)
  );
  bacl_sync uFreq
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pinIn   (input_frequency_stable),
    .level   (freqStableS)
  );
  // each mode bit settles on its own; both are stable long before a read
  bacl_sync uPm0
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pinIn   (portModeIn[0]),
    .level   (portModeS[0])
  );
  bacl_sync uPm1
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pinIn   (portModeIn[1]),
    .level   (portModeS[1])
  );

  // watch each audio event field, armed by its config bit
  bacl_change_det #(.WIDTH(4)) uType
  (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .sampleValid (audioInfoValid),
    .watched     (audioType),
    .armed       (audio_configuration[bacl_pkg::RESET_ON_TYPE_BIT]),
    .changed     (typeChanged)
  );
  bacl_change_det #(.WIDTH(8)) uAudIf
  (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .sampleValid (audioInfoValid),
    .watched     (audioIfChecksum),
    .armed       (audio_configuration[bacl_pkg::RESET_ON_AUD_IF_BIT]),
    .changed     (audIfChanged)
  );
  bacl_change_det #(.WIDTH(8)) uVidIf
  (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .sampleValid (audioInfoValid),
    .watched     (videoIfChecksum),
    .armed       (audio_configuration[bacl_pkg::RESET_ON_VID_IF_BIT]),
    .changed     (vidIfChanged)
  );
  // n and cts watched as one word: a change in either field counts
  bacl_change_det #(.WIDTH(40)) uRegen
  (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .sampleValid (audioInfoValid),
    .watched     (clockRegenNCts),
    .armed       (audio_configuration[bacl_pkg::RESET_ON_CLK_REGEN_BIT]),
    .changed     (regenChanged)
  );

  // transmit status only once input valid and mode entered
  assign txStatus = txActiveS && remoteLockedS && modeSettledS
                    && tmdsValidS;
  // hdmi pin output only honoured when source is hdmi audio
  assign hdmiOutAllowed =
    audio_configuration[bacl_pkg::HDMI_I2S_OUT_BIT] &&
    !bridge_configuration[bacl_pkg::AUDIO_SOURCE_BIT];

  // status word built from synchronised levels
  always_comb
  begin
    link_and_input_status = 8'h00;
    link_and_input_status[bacl_pkg::LINK_READY_BIT]  = linkReadyS;
    link_and_input_status[bacl_pkg::TX_STATUS_BIT]   = txStatus;
    // mode field meaningful only while transmitting
    link_and_input_status[bacl_pkg::PORT_MODE_LSB +: 2] =
      txStatus ? portModeS : bacl_pkg::PORT_MODE_RESET;
    link_and_input_status[bacl_pkg::TMDS_DATA_VALID_BIT]  = tmdsValidS;
    link_and_input_status[bacl_pkg::PLL_LOCK_BIT]    = pllLockS;
    link_and_input_status[bacl_pkg::NO_CLOCK_BIT]    = !clkPresentS;
    link_and_input_status[bacl_pkg::INPUT_FREQUENCY_STABLE_BIT] = freqStableS;
  end

  // writable registers; status is read-only and ignores writes
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      audio_configuration  <= bacl_pkg::AUDIO_CONFIGURATION_RESET;
      bridge_configuration <= bacl_pkg::BRIDGE_CONFIGURATION_RESET;
    end
    else if (regWrite)
    begin
      case (regAddr)
        bacl_pkg::AUDIO_CONFIGURATION_ADDR:
          // reserved bits 5:4 stay zero
          audio_configuration <=
            regWrData & bacl_pkg::AUDIO_CONFIGURATION_MASK;
        bacl_pkg::BRIDGE_CONFIGURATION_ADDR:
          bridge_configuration <= regWrData;
        default:
          ; // unmapped or read-only: ignored
      endcase
    end
  end

  // read data, one cycle after the read strobe
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regRdData  <= 8'h00;
      regRdValid <= 1'b0;
    end
    else
    begin
      regRdValid <= regRead;
      if (regRead)
      begin
        case (regAddr)
          bacl_pkg::AUDIO_CONFIGURATION_ADDR:
            regRdData <= audio_configuration;
          bacl_pkg::BRIDGE_CONFIGURATION_ADDR:
            regRdData <= bridge_configuration;
          bacl_pkg::LINK_AND_INPUT_STATUS_ADDR:
            regRdData <= link_and_input_status;
          default:
            regRdData <= 8'h00; // unmapped reads zero
        endcase
      end
    end
  end

  // converter enable and audio source registered outputs
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tdmParallelEnable <= 1'b0;
      audioFromLocal    <= 1'b0;
    end
    else
    begin
      tdmParallelEnable <=
        audio_configuration[bacl_pkg::TDM_PARALLEL_BIT];
      audioFromLocal <=
        bridge_configuration[bacl_pkg::AUDIO_SOURCE_BIT];
    end
  end

  // transmit clock choice, retimed at sys_clk
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      audioTxClk <= 1'b0;
    else if (audio_configuration[bacl_pkg::TDM_PARALLEL_BIT])
      audioTxClk <= tdmConvClk;
    else
      audioTxClk <= hdmiAudioClk;
  end

  // i2s pins carry hdmi audio only when allowed
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      i2sClkOut  <= 1'b0;
      i2sDataOut <= 1'b0;
      i2sWsOut   <= 1'b0;
      i2sPinOe   <= 1'b0;
    end
    else
    begin
      i2sPinOe   <= hdmiOutAllowed;
      i2sClkOut  <= hdmiOutAllowed & hdmiI2sClk;
      i2sDataOut <= hdmiOutAllowed & hdmiI2sData;
      i2sWsOut   <= hdmiOutAllowed & hdmiI2sWs;
    end
  end

  // one-cycle fifo reset on any armed event
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      audioFifoReset <= 1'b0;
    else
      audioFifoReset <= typeChanged | audIfChanged | vidIfChanged
                        | regenChanged;
  end
endmodule : bacl_regs

// ===== tb/bacl_regs_assertions.sv
// watches the register block ports from outside
module bacl_regs_assertions
(
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regRdValid,
  input wire logic       tdmParallelEnable,
  input wire logic       audioTxClk,
  input wire logic       tdmConvClk,
  input wire logic       hdmiAudioClk,
  input wire logic       i2sPinOe,
  input wire logic       i2sClkOut,
  input wire logic       i2sDataOut,
  input wire logic       hdmiI2sClk,
  input wire logic       hdmiI2sData,
  input wire logic       hdmiI2sWs,
  input wire logic       i2sWsOut,
  input wire logic       audioFromLocal,
  input wire logic       audioFifoReset,
  input wire logic       audioInfoValid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dcb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // enable bit follows a config write after two edges
  tdm_enable_a:
    assert property (regWrite && regAddr == 8'h55 |=> ##1
      tdmParallelEnable == $past(regWrData[7], 2)) else $error("tdm enable");
  // tx clock comes from converter only while enabled
  tx_clk_sel_a:
    assert property ($past(rst_n, 2) |-> audioTxClk == (tdmParallelEnable ?
      $past(tdmConvClk) : $past(hdmiAudioClk))) else $error("tx clock");
  // pins carry the hdmi stream while driven
  i2s_pass_a:
    assert property ($past(rst_n, 2) && i2sPinOe && $past(i2sPinOe) |->
      i2sClkOut == $past(hdmiI2sClk) && i2sDataOut == $past(hdmiI2sData)
      && i2sWsOut == $past(hdmiI2sWs)) else $error("i2s pass");
  // pins stay low while not driven
  i2s_quiet_a:
    assert property (!i2sPinOe && !$past(i2sPinOe) |->
      !i2sClkOut && !i2sDataOut && !i2sWsOut) else $error("i2s quiet");
  // local source blocks the pin output
  source_gate_a:
    assert property (audioFromLocal && $past(audioFromLocal) |-> !i2sPinOe)
      else $error("source gate");
  // fifo reset is a single cycle
  fifo_pulse_a:
    assert property (audioFifoReset |=> !audioFifoReset)
      else $error("fifo pulse");
  // fifo reset only after a sampled event
  fifo_cause_a:
    assert property (audioFifoReset |-> $past(audioInfoValid, 2) ||
      $past(audioInfoValid, 3)) else $error("fifo cause");
  // every read is answered next cycle
  read_answer_a:
    assert property (regRead |=> regRdValid) else $error("read answer");
  cover property (audioFifoReset);
  cover property (i2sPinOe);
  cover property (tdmParallelEnable && audioTxClk);
endmodule : bacl_regs_assertions

bind bacl_regs bacl_regs_assertions chk (.sys_clk, .rst_n, .regWrite,
  .regRead, .regAddr, .regWrData, .regRdValid, .tdmParallelEnable,
  .audioTxClk, .tdmConvClk, .hdmiAudioClk, .i2sPinOe, .i2sClkOut,
  .i2sDataOut, .hdmiI2sClk, .hdmiI2sData, .hdmiI2sWs, .i2sWsOut,
  .audioFromLocal, .audioFifoReset, .audioInfoValid);

// ===== tb/bacl_src_model.sv
// hdmi side: event packets and free running audio clocks
module bacl_src_model
(
  input  wire logic        sys_clk,
  input  wire logic        evtReq,
  input  wire logic [59:0] evtWord,
  output logic             audioInfoValid,
  output logic [3:0]       audioType,
  output logic [7:0]       audioIfChecksum,
  output logic [7:0]       videoIfChecksum,
  output logic [39:0]      clockRegenNCts,
  output logic             hdmiI2sClk,
  output logic             hdmiI2sData,
  output logic             hdmiI2sWs,
  output logic             tdmConvClk,
  output logic             hdmiAudioClk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [59:0] held; // packet fields
  logic [3:0]  cnt;  // clock divider
  initial
  begin
    held = 60'h0;
    cnt = 4'h0;
    audioInfoValid = 1'h0;
  end
  // fields flip outside the strobe so stale values never look valid
  // launched on the rising edge, clear of the bench's falling-edge request
  always @(posedge sys_clk)
  begin
    audioInfoValid <= evtReq;
    held <= evtReq ? evtWord : ~held;
    cnt <= cnt + 4'h1;
  end
  assign {audioType, audioIfChecksum, videoIfChecksum, clockRegenNCts} = held;
  assign hdmiI2sClk = cnt[0];
  assign hdmiI2sData = cnt[1] ^ cnt[3];
  assign hdmiI2sWs = cnt[3];
  assign tdmConvClk = cnt[1];
  assign hdmiAudioClk = cnt[2];
endmodule : bacl_src_model

// ===== tb/bridge_audio_cfg_link_status_bench.sv
// register, status and audio event checks
module bridge_audio_cfg_link_status_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'h0, rst_n, regWrite, regRead, regRdValid, evtReq;
  logic [7:0] regAddr, regWrData, regRdData, audioIfChecksum, videoIfChecksum;
  logic [9:0] st; // status pin vector
  logic [59:0] evtWord, w;
  logic [39:0] clockRegenNCts;
  logic [3:0] audioType;
  logic [7:0] n;
  logic [7:0] outs; // converter enable, pin enable, source select
  logic downstream_link_ready, remoteLocked, transmitterActive, modeSettled;
  logic tmds_data_valid, hdmiPllLock, tmdsClockPresent, input_frequency_stable;
  logic [1:0] portModeIn;
  logic audioInfoValid, hdmiI2sClk, hdmiI2sData, hdmiI2sWs, tdmConvClk;
  logic hdmiAudioClk, tdmParallelEnable, audioTxClk, audioFromLocal;
  logic i2sClkOut, i2sDataOut, i2sWsOut, i2sPinOe, audioFifoReset;
  int n_fail = 0, checks = 0;
  // status cases: single pins, transmit in each mode, missing conditions
  localparam logic [9:0] SV [12] = '{10'h000, 10'h200, 10'h008, 10'h004,
    10'h002, 10'h001, 10'h1C8, 10'h1D8, 10'h1E8, 10'h1F8, 10'h1B8, 10'h1F0};
  // one flipped bit per event field: type, audio, video, clock regen
  localparam logic [59:0] FM [4] = '{60'h100000000000000, 60'h1000000000000,
    60'h10000000000, 60'h1};
  always #5 sys_clk = ~sys_clk;
  assign {downstream_link_ready, remoteLocked, transmitterActive, modeSettled,
    portModeIn, tmds_data_valid, hdmiPllLock, tmdsClockPresent,
    input_frequency_stable} = st;
  assign outs = {5'h00, tdmParallelEnable, i2sPinOe, audioFromLocal};
  bacl_regs dut (.sys_clk, .rst_n, .regWrite, .regRead, .regAddr, .regWrData,
    .regRdData, .regRdValid, .downstream_link_ready, .remoteLocked,
    .transmitterActive, .modeSettled, .portModeIn, .tmds_data_valid,
    .hdmiPllLock, .tmdsClockPresent, .input_frequency_stable, .audioInfoValid,
    .audioType, .audioIfChecksum, .videoIfChecksum, .clockRegenNCts,
    .hdmiI2sClk, .hdmiI2sData, .hdmiI2sWs, .tdmConvClk, .hdmiAudioClk,
    .tdmParallelEnable, .audioTxClk, .audioFromLocal, .i2sClkOut,
    .i2sDataOut, .i2sWsOut, .i2sPinOe, .audioFifoReset);
  bacl_src_model src (.sys_clk, .evtReq, .evtWord, .audioInfoValid,
    .audioType, .audioIfChecksum, .videoIfChecksum, .clockRegenNCts,
    .hdmiI2sClk, .hdmiI2sData, .hdmiI2sWs, .tdmConvClk, .hdmiAudioClk);
  // expected status byte from the pin levels
  function automatic logic [7:0] expSt(input logic [9:0] s);
    logic tx;
    tx = s[8] & s[7] & s[6] & s[3];
    return {s[9], tx, tx ? s[5:4] : 2'h0, s[3], s[2], ~s[1], s[0]};
  endfunction : expSt
  task cmp(input logic [7:0] got, input logic [7:0] e);
    checks++;
    if (got !== e)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, e);
    end
  endtask : cmp
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    {regWrite, regAddr, regWrData} = {1'h1, a, d};
    @(negedge sys_clk);
    regWrite = 1'h0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    int i;
    @(negedge sys_clk);
    {regRead, regAddr} = {1'h1, a};
    @(negedge sys_clk);
    regRead = 1'h0;
    for (i = 0; i < 4 && regRdValid !== 1'h1; i++)
      @(negedge sys_clk);
    cmp({7'h00, regRdValid}, 8'h01);
    cmp(regRdData, e);
  endtask : rd
  // send one packet, count fifo resets that follow
  task evt(input logic [59:0] v);
    @(negedge sys_clk);
    {evtReq, evtWord} = {1'h1, v};
    @(negedge sys_clk);
    evtReq = 1'h0;
    n = 8'h00;
    repeat (6)
    begin
      @(negedge sys_clk);
      n = n + {7'h00, audioFifoReset};
    end
  endtask : evt
  task print_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  // stops a hung run
  initial
  begin
    #200000;
    n_fail++;
    print_verdict;
  end
  initial
  begin
    {rst_n, regWrite, regRead, regAddr, regWrData, evtReq} = '0;
    {st, evtWord, w} = '0;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'h1;
    evt(w);
    repeat (8) @(negedge sys_clk);
    rd(8'h55, 8'h0C);
    rd(8'h77, 8'h00);
    wr(8'h55, 8'hFF);
    rd(8'h55, 8'hCF);
    wr(8'h5A, 8'hFF);
    rd(8'h5A, 8'h02);
    for (int i = 0; i < 12; i++)
    begin
      st = SV[i];
      repeat (8) @(negedge sys_clk);
      rd(8'h5A, expSt(SV[i]));
    end
    for (int b = 0; b < 4; b++)
    begin
      wr(8'h55, 8'h01 << b);
      for (int f = 0; f < 4; f++)
      begin
        w = w ^ FM[f];
        evt(w);
        cmp(n, {7'h00, f == 3 - b});
      end
    end
    wr(8'h54, 8'h00);
    wr(8'h55, 8'hC0);
    repeat (4) @(negedge sys_clk);
    cmp(outs, 8'h06);
    wr(8'h54, 8'h02);
    repeat (4) @(negedge sys_clk);
    cmp(outs, 8'h05);
    wr(8'h55, 8'h40);
    wr(8'h54, 8'h00);
    repeat (4) @(negedge sys_clk);
    cmp(outs, 8'h02);
    print_verdict;
  end
endmodule : bridge_audio_cfg_link_status_bench
